// ### common/dac_load_cfg.svh
`ifndef DAC_LOAD_CFG_SVH
`define DAC_LOAD_CFG_SVH
// word geometry
`define WORD_BITS 16
`define BIT_COUNT_BITS 5
`define FRAME_BITS 5'h10
// latch value that gives zero volts
`define MIDCODE 16'h0000
// fifo shape
`define FIFO_DEPTH 8
`define FIFO_PTR_BITS 3
// output settle time after load, in ns, and cycles at 8 ns clock (least: round up)
`define SYS_CLK_NS 8
`define OUTPUT_UPDATE_DELAY_NS 1000
`define OUTPUT_UPDATE_DELAY_CYC ((`OUTPUT_UPDATE_DELAY_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define SETTLE_BITS 8
`endif

// ### common/dac_load_pkg.sv
`include "dac_load_cfg.svh"
package dac_load_pkg;
    typedef logic [`WORD_BITS-1:0] word_t;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_shift = 2'b01,
        st_load = 2'b11,
        st_done = 2'b10
    } frame_state_t;
endpackage : dac_load_pkg

// ### hdl/dac_word_fifo.sv
// the word fifo module sits in the main design file, beside its only user

// ### hdl/dac_serial_load_and_clear.sv
// Overview of operation
// - falling chip-select starts a frame and clears the bit count.
// - each of the first sixteen rising bit clocks while selected shifts data in, MSB first.
// - after sixteen rising edges, the next falling edge updates the latch.
// - after the update, further clocks and data are ignored until reselect.
// - the next chip-select falling edge restarts from the first bit.
// - deselect before the update discards the word, latch unchanged.
// - clear low in the sixteenth cycle loads midcode, zero volts.
// - clear high in the sixteenth cycle loads the shifted word.
// - clear released mid-frame keeps midcode until next normal load.
// - clear never stops or corrupts serial shifting.
// - latch word is twos complement; 0000 is zero volts.
// - while chip-select is high, clock and data are ignored.
`include "dac_load_cfg.svh"
module dac_serial_load_and_clear
    import dac_load_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial pins from the controller
    input wire logic chip_select_n,
    input wire logic bit_clock,
    input wire logic serial_word_in,
    input wire logic force_midscale_n,
    // converter latch and status
    output word_t latch_word,
    output logic latch_load,
    output logic output_settled,
    // loaded-word stream
    output logic word_valid,
    input wire logic word_ready,
    output word_t word_data
);
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [1:0] prev;
        frame_state_t state;
        logic [`BIT_COUNT_BITS-1:0] bit_count;
        word_t shift;
        logic clear_seen;
        word_t latch;
        logic load;
        logic [`SETTLE_BITS-1:0] settle;
    } ctrl_state_t;
    ctrl_state_t s;
    ctrl_state_t next_s;
    logic cs_n;
    logic sck;
    logic sdi;
    logic clr_n;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    // synchronised pin views
    assign cs_n = s.sync2[3];
    assign sck = s.sync2[2];
    assign sdi = s.sync2[1];
    assign clr_n = s.sync2[0];
    assign cs_fall = s.prev[1] && !cs_n;
    assign sck_rise = !s.prev[0] && sck;
    assign sck_fall = s.prev[0] && !sck;
    // frame sequencing
    always_comb begin
        next_s = s;
        next_s.sync1 = {chip_select_n, bit_clock, serial_word_in, force_midscale_n};
        next_s.sync2 = s.sync1;
        next_s.prev = {cs_n, sck};
        next_s.load = 1'b0;
        if (s.settle != '0) begin
            next_s.settle = s.settle - 1'b1;
        end
        if (cs_fall) begin
            next_s.state = st_shift;
            next_s.bit_count = '0;
        end else if (cs_n) begin
            next_s.state = st_idle;
            next_s.bit_count = '0;
        end else begin
            case (s.state)
                st_shift: begin
                    if (sck_rise) begin
                        next_s.shift = {s.shift[`WORD_BITS-2:0], sdi};
                        next_s.bit_count = s.bit_count + 1'b1;
                        if (s.bit_count == `FRAME_BITS - 5'h01) begin
                            next_s.state = st_load;
                        end
                    end
                end
                st_load: begin
                    // clear level sampled through the sixteenth cycle
                    if (!clr_n) begin
                        next_s.clear_seen = 1'b1;
                    end
                    if (sck_fall) begin
                        if (!clr_n || s.clear_seen) begin
                            next_s.latch = `MIDCODE;
                        end else begin
                            next_s.latch = s.shift;
                        end
                        next_s.clear_seen = 1'b0;
                        next_s.load = 1'b1;
                        next_s.settle = `SETTLE_BITS'(`OUTPUT_UPDATE_DELAY_CYC);
                        next_s.state = st_done;
                    end
                end
                st_done: begin
                    next_s.state = st_done;
                end
                default: begin
                    next_s.state = st_idle;
                end
            endcase
            // a low clear in the cycle opening the sixteenth bit counts too
            if (s.state == st_shift && sck_rise && s.bit_count == `FRAME_BITS - 5'h01) begin
                next_s.clear_seen = !clr_n;
            end
        end
    end
    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
            // idle pin levels: deselected, clock low, clear off, so no false edge
            s.sync1 <= 4'h9;
            s.sync2 <= 4'h9;
            s.prev <= 2'h2;
            s.state <= st_idle;
            s.latch <= `MIDCODE;
        end else begin
            s <= next_s;
        end
    end
    assign latch_word = s.latch;
    assign latch_load = s.load;
    assign output_settled = (s.settle == '0);
    // loaded words queued for downstream
    dac_word_fifo #(
        .WIDTH(`WORD_BITS),
        .DEPTH(`FIFO_DEPTH),
        .PTR_BITS(`FIFO_PTR_BITS)
    ) u_dac_word_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(s.load),
        .in_ready(),
        .in_data(s.latch),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule : dac_serial_load_and_clear

// small word fifo, valid and ready on both sides; a push while full is dropped
module dac_word_fifo #(
    parameter int WIDTH = `WORD_BITS,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int PTR_BITS = `FIFO_PTR_BITS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [PTR_BITS-1:0] wr_ptr;
        logic [PTR_BITS-1:0] rd_ptr;
        logic [PTR_BITS:0] count;
    } fifo_state_t;
    fifo_state_t s;
    fifo_state_t next_s;
    // storage is not reset; only pointers and count are
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    // honest full and empty
    assign in_ready = (s.count != (PTR_BITS+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data = mem[s.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // pointer and count update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end
    // state and storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
        if (push) begin
            mem[s.wr_ptr] <= in_data;
        end
    end
endmodule : dac_word_fifo

// ### bench/dac_host.sv
module dac_host (
    // serial pins toward the device
    output logic cs_n,
    output logic sclk,
    output logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdo = 1'b0;
    end
    // stray pulse while deselected, then n bits msb first at 8 MHz
    task automatic send(input logic [15:0] w, input int n);
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdo = w[15 - i % 16];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        sdo = ~sdo;
        #125 cs_n = 1'b1;
        #250;
    endtask : send
endmodule : dac_host

// ### bench/dac_load_chk.sv
`include "dac_load_cfg.svh"
module dac_load_chk
    import dac_load_pkg::*;
(
    // watched ports
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic force_midscale_n,
    input wire word_t latch_word,
    input wire logic latch_load,
    input wire logic output_settled,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire word_t word_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since the last latch load, saturating
    logic [7:0] load_age;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            load_age <= 8'hff;
        end else if (latch_load) begin
            load_age <= 8'h01;
        end else if (load_age != 8'hff) begin
            load_age <= load_age + 8'h01;
        end
    end
    // latch, settle flag and stream relations
    a_reset_mid: assert property (disable iff (1'b0) rst |=> latch_word == `MIDCODE)
        else $error("reset");
    a_load_pulse: assert property (latch_load |=> !latch_load) else $error("pulse");
    a_latch_hold: assert property ($changed(latch_word) |-> latch_load || $past(latch_load))
        else $error("hold");
    a_idle_quiet: assert property (chip_select_n [*8] |=> !latch_load) else $error("idle");
    a_clear_mid: assert property (!force_midscale_n [*8] ##1 latch_load |=> latch_word == 0)
        else $error("clear");
    a_settle_low: assert property (latch_load |=> !output_settled [*8]) else $error("low");
    a_settle_end: assert property (!latch_load |->
        output_settled == (load_age >= `OUTPUT_UPDATE_DELAY_CYC)) else $error("settle");
    a_fifo_hold: assert property (word_valid && !word_ready |=>
        word_valid && $stable(word_data)) else $error("fifo");
endmodule : dac_load_chk
bind dac_serial_load_and_clear dac_load_chk u_dac_load_chk (.sys_clk(sys_clk), .rst(rst),
    .chip_select_n(chip_select_n), .force_midscale_n(force_midscale_n),
    .latch_word(latch_word), .latch_load(latch_load), .output_settled(output_settled),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));

// ### bench/dac_serial_load_and_clear_tb_top.sv
`include "dac_load_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h", $time, a); end end
module dac_serial_load_and_clear_tb_top;
    import dac_load_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst = 1'b1, midscale_n = 1'b1, word_ready = 1'b0, ph = 1'b0;
    logic cs_n, sclk, sdo, latch_load, settled, valid;
    word_t latch_word, word_data, w;
    word_t exp_q[$], str_q[$];
    int n_mismatch = 0, num_checks = 0, seed = 83, nstr = 0;
    dac_host u_dac_host (.cs_n(cs_n), .sclk(sclk), .sdo(sdo));
    dac_serial_load_and_clear u_dac_serial_load_and_clear (.sys_clk(sys_clk), .rst(rst),
        .chip_select_n(cs_n), .bit_clock(sclk), .serial_word_in(sdo),
        .force_midscale_n(midscale_n), .latch_word(latch_word), .latch_load(latch_load),
        .output_settled(settled), .word_valid(valid), .word_ready(word_ready),
        .word_data(word_data));
    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // drain side held off until fill is done, then random stalls
    always @(negedge sys_clk) word_ready <= ph && ($random(seed) & 1);
    // compare each load and each drained word with the oldest note
    always @(posedge sys_clk) begin
        if (latch_load === 1'b1) `CHK(latch_word, exp_q.size() ? exp_q.pop_front() : 'x)
        if (valid === 1'b1 && word_ready) `CHK(word_data, str_q.size() ? str_q.pop_front() : 'x)
    end
    // one frame; full fifo drops the word from the stream only
    task automatic frame(input word_t d, input int n, input logic ld, input word_t e);
        if (ld) exp_q.push_back(e);
        if (ld && (ph || nstr < `FIFO_DEPTH)) begin
            str_q.push_back(e);
            nstr++;
        end
        u_dac_host.send(d, n);
    endtask : frame
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        #100us;
        frame(16'h7fff, 16, 1'b1, 16'h7fff);
        frame(16'h8000, 16, 1'b1, 16'h8000);
        frame(16'h1234, 10, 1'b0, 16'h0000);
        frame(16'ha5c3, 20, 1'b1, 16'ha5c3);
        @(negedge sys_clk) midscale_n = 1'b0;
        frame(16'h5a5a, 16, 1'b1, `MIDCODE);
        fork
            frame(16'h3c3c, 16, 1'b1, 16'h3c3c);
            #1us @(negedge sys_clk) midscale_n = 1'b1;
        join
        for (int i = 0; i < 8; i++) begin
            ph = (i > 4);
            w = word_t'($random(seed));
            frame(w, 16, 1'b1, w);
        end
        repeat (200) @(posedge sys_clk);
        `CHK(exp_q.size() + str_q.size(), 0)
        summarize();
    end
    // hang guard
    initial begin
        #300us;
        n_mismatch++;
        summarize();
    end
endmodule : dac_serial_load_and_clear_tb_top
